// ---- hw/ejector_bank.sv ----
// Notes on behaviour
// R1 - leak limit per ejector, 0..999, default 250
// R2 - index n addresses ejector n plus one
// R3 - leakage measured only after upper point cutoff
// R4 - four counters owned by each ejector
// R5 - suction cycles counted at 0x8C, 0x8F
// R6 - valve switchings counted at 0x8D, 0x90
// R7 - only command clears clearable; permanent never cleared
// R8 - save to storage every 256 increments
// R9 - permanent counters read-only, up to 999999
// R10 - clearable counters read-only, up to 999999999
// R11 - manual mode follows panel button
// R12 - manual mode disables valve protection
// R13 - leakage over limit thrice forces continuous suction
// R14 - counters saturate at maximum
//
// Implementation choice: register access over Avalon-MM.
`include "ejector_bank_defines.svh"
`default_nettype none
module ejector_bank (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] suction_cmd,
  input wire logic [15:0] blow_cmd,
  input wire logic [15:0] suction_valve,
  input wire logic [15:0] upper_vacuum_switch_point,
  input wire logic [15:0] leak_valid,
  input wire logic [255:0] leak_rate,
  input wire logic panel_suction_btn,
  input wire logic panel_blow_btn,
  output logic [15:0] suction_out,
  output logic [15:0] blow_out,
  output logic valve_protect_en,
  output logic [15:0] force_continuous,
  output logic [15:0] save_req
);
  // ==========================================================
  // pin synchronisers, three stages; a change counts once stages two and three agree
  logic [15:0] vs1;
  logic [15:0] vs2;
  logic [15:0] vs3;
  logic [15:0] vstate;
  logic [15:0] us1;
  logic [15:0] us2;
  logic [15:0] us3;
  logic [15:0] ustate;
  logic [1:0] b1;
  logic [1:0] b2;
  logic [1:0] b3;
  logic [1:0] bstate;
  // filtered levels hold while the two late stages disagree
  wire logic [15:0] next_vstate = (vs2 & vs3) | (vstate & (vs2 | vs3));
  wire logic [15:0] next_ustate = (us2 & us3) | (ustate & (us2 | us3));
  wire logic [1:0] next_bstate = (b2 & b3) | (bstate & (b2 | b3));

  // first stage, the only reader of the pins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vs1 <= 16'h0000;
      us1 <= 16'h0000;
      b1 <= 2'h0;
    end else begin
      vs1 <= suction_valve;
      us1 <= upper_vacuum_switch_point;
      b1 <= {panel_blow_btn, panel_suction_btn};
    end
  end

  // second and third stages
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vs2 <= 16'h0000;
      vs3 <= 16'h0000;
      us2 <= 16'h0000;
      us3 <= 16'h0000;
      b2 <= 2'h0;
      b3 <= 2'h0;
    end else begin
      vs2 <= vs1;
      vs3 <= vs2;
      us2 <= us1;
      us3 <= us2;
      b2 <= b1;
      b3 <= b2;
    end
  end

  // filtered levels, low after reset like the idle pins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vstate <= 16'h0000;
      ustate <= 16'h0000;
      bstate <= 2'h0;
    end else begin
      vstate <= next_vstate;
      ustate <= next_ustate;
      bstate <= next_bstate;
    end
  end

  // ==========================================================
  // register bus
  ejector_bank_pkg::bus_state_e state;
  ejector_bank_pkg::bus_state_e next_state;
  logic [15:0] leak_limit [16];
  logic leak_mon_en;
  logic manual_mode;
  logic [15:0] clear_cyc;
  logic [15:0] clear_vlv;
  wire logic [31:0] cyc_perm [16];
  wire logic [31:0] vlv_perm [16];
  wire logic [31:0] cyc_clr [16];
  wire logic [31:0] vlv_clr [16];
  wire logic [15:0] save_w;
  wire logic [15:0] force_w;

  // parameter index in the upper address bits, ejector in the low nibble
  wire logic [11:0] idx = {2'h0, avs_address[13:4]};
  wire logic [3:0] ej = avs_address[3:0]; // R2
  wire logic bus_req = avs_read || avs_write;
  wire logic accept = (state == ejector_bank_pkg::st_idle) && bus_req;
  // a write lands at the edge where waitrequest is seen low
  wire logic wr_take = (state == ejector_bank_pkg::st_read) && avs_write;
  wire logic hit_limit = (idx == `IDX_LEAK_LIMIT);
  wire logic hit_control = (idx == `IDX_CONTROL);
  wire logic hit_clear = (idx == `IDX_CLEAR_CMD);

  // leak limit write, byte lanes merged with the old value
  wire logic [7:0] limit_hi = avs_byteenable[1] ? avs_writedata[15:8] : leak_limit[ej][15:8];
  wire logic [7:0] limit_lo = avs_byteenable[0] ? avs_writedata[7:0] : leak_limit[ej][7:0];
  wire logic [15:0] limit_merged = {limit_hi, limit_lo};
  // a value above the range is refused and the old one kept
  wire logic limit_ok = (limit_merged <= `LEAK_LIMIT_MAX); // R1
  wire logic limit_we = wr_take && hit_limit && limit_ok; // R1

  // clear command: one-cycle pulse to the named ejector
  wire logic clr_we = wr_take && hit_clear;
  wire logic [15:0] clr_sel = 16'h0001 << avs_writedata[3:0];
  wire logic [15:0] next_clear_cyc =
    (clr_we && avs_writedata[`CLR_CYC_BIT]) ? clr_sel : 16'h0000;
  wire logic [15:0] next_clear_vlv =
    (clr_we && avs_writedata[`CLR_VLV_BIT]) ? clr_sel : 16'h0000;

  // control word: bit 0 leak monitoring, bit 1 manual mode
  wire logic [31:0] ctl_word = {30'h0, manual_mode, leak_mon_en};
  wire logic [31:0] status_word = {16'h0000, force_w};
  // read selection; counters are read-only, an unknown index reads zero
  wire logic [31:0] read_mux =
    (idx == `IDX_LEAK_LIMIT) ? {16'h0000, leak_limit[ej]} :
    (idx == `IDX_CYC_PERM) ? cyc_perm[ej] : // R5 R9
    (idx == `IDX_VLV_PERM) ? vlv_perm[ej] : // R6 R9
    (idx == `IDX_CYC_CLR) ? cyc_clr[ej] : // R5 R10
    (idx == `IDX_VLV_CLR) ? vlv_clr[ej] : // R6 R10
    (idx == `IDX_CONTROL) ? ctl_word :
    (idx == `IDX_STATUS) ? status_word :
    32'h00000000;

  // next bus state: accept, answer, then one cycle for the release
  // the answer comes one cycle after the request is first seen;
  // the done cycle keeps a held request from being taken twice
  always_comb begin
    next_state = state;
    case (state)
      ejector_bank_pkg::st_idle: begin
        if (bus_req) next_state = ejector_bank_pkg::st_read;
      end
      ejector_bank_pkg::st_read: begin
        next_state = ejector_bank_pkg::st_done;
      end
      ejector_bank_pkg::st_done: begin
        next_state = ejector_bank_pkg::st_idle;
      end
      default: begin
        next_state = ejector_bank_pkg::st_idle;
      end
    endcase
  end

  // bus answer: waitrequest drops for one cycle with the read data standing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ejector_bank_pkg::st_idle;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      state <= next_state;
      avs_waitrequest <= !accept;
      if (accept) avs_readdata <= read_mux;
    end
  end

  // control register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      leak_mon_en <= 1'b0;
      manual_mode <= 1'b0;
    end else if (wr_take && hit_control) begin
      leak_mon_en <= avs_writedata[`CTL_LEAK_MON_BIT];
      manual_mode <= avs_writedata[`CTL_MANUAL_BIT]; // R11
    end
  end

  // clear pulses, high for the cycle after the write lands
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clear_cyc <= 16'h0000;
      clear_vlv <= 16'h0000;
    end else begin
      clear_cyc <= next_clear_cyc; // R7
      clear_vlv <= next_clear_vlv; // R7
    end
  end

  // leak limit per ejector, index n is ejector n plus one
  for (genvar i = 0; i < 16; i++) begin : g_limit
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        leak_limit[i] <= `LEAK_LIMIT_RESET; // R1
      end else if (limit_we && (ej == 4'(i))) begin
        leak_limit[i] <= limit_merged; // R1 R2
      end
    end
    a_limit_range: assert property (@(posedge core_clk) disable iff (!rstn) // R1
      leak_limit[i] <= `LEAK_LIMIT_MAX) else $error("leak limit out of range");
  end

  // ==========================================================
  // suction, blow and valve events
  logic [15:0] suction_prev;
  logic [15:0] valve_prev;
  // manual mode hands suction and blow to the panel button, all ejectors alike
  wire logic [15:0] suction_sig = manual_mode ? {16{bstate[0]}} : suction_cmd; // R11
  wire logic [15:0] blow_sig = manual_mode ? {16{bstate[1]}} : blow_cmd; // R11
  // rising edges; previous levels reset to the idle low of the inputs
  wire logic [15:0] suction_rise = suction_sig & ~suction_prev; // R5
  wire logic [15:0] valve_rise = vstate & ~valve_prev; // R6
  // air saving cuts suction at the upper point while regulation runs
  wire logic [15:0] regulating = ~force_w & {16{!manual_mode}};
  wire logic [15:0] air_cut = suction_sig & ustate & regulating;
  // leakage is only measured while suction stands cut
  wire logic [15:0] meas_valid = leak_valid & air_cut; // R3

  // edge history
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      suction_prev <= 16'h0000;
      valve_prev <= 16'h0000;
    end else begin
      suction_prev <= suction_sig;
      valve_prev <= vstate;
    end
  end

  // pin outputs, each from a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      suction_out <= 16'h0000;
      blow_out <= 16'h0000;
      valve_protect_en <= 1'b1;
    end else begin
      suction_out <= suction_sig & ~air_cut; // R11 R13
      blow_out <= blow_sig; // R11
      valve_protect_en <= !manual_mode; // R12
    end
  end

  // one channel of counters and leak trip per ejector
  for (genvar i = 0; i < 16; i++) begin : g_chan
    ejector_channel u_chan (
      .core_clk(core_clk),
      .rstn(rstn),
      .suction_rise(suction_rise[i]),
      .valve_rise(valve_rise[i]),
      .clear_cyc(clear_cyc[i]),
      .clear_vlv(clear_vlv[i]),
      .leak_valid(meas_valid[i]),
      .leak_rate(leak_rate[16*i +: 16]),
      .leak_limit(leak_limit[i]),
      .leak_mon_en(leak_mon_en),
      .cyc_perm(cyc_perm[i]),
      .vlv_perm(vlv_perm[i]),
      .cyc_clr(cyc_clr[i]),
      .vlv_clr(vlv_clr[i]),
      .save_req(save_w[i]),
      .force_continuous(force_w[i])
    );
  end

  // channel flops drive the status outputs directly
  assign force_continuous = force_w; // R13
  assign save_req = save_w; // R8

  // ==========================================================
  // checks
  a_protect_manual: assert property (@(posedge core_clk) disable iff (!rstn) // R12
    manual_mode |=> !valve_protect_en) else $error("protection on in manual mode");
  a_manual_suction: assert property (@(posedge core_clk) disable iff (!rstn) // R11
    manual_mode && bstate[0] |=> suction_out == 16'hFFFF) else $error("button ignored");
endmodule : ejector_bank
`default_nettype wire

// ---- hw/ejector_bank_defines.svh ----
`ifndef EJECTOR_BANK_DEFINES_SVH
`define EJECTOR_BANK_DEFINES_SVH
// register indices, carried in the upper address bits above the ejector nibble
`define IDX_LEAK_LIMIT 12'h06C
`define IDX_CYC_PERM 12'h08C
`define IDX_VLV_PERM 12'h08D
`define IDX_CYC_CLR 12'h08F
`define IDX_VLV_CLR 12'h090
`define IDX_CONTROL 12'h0A0
`define IDX_CLEAR_CMD 12'h0A1
`define IDX_STATUS 12'h0A2
// field positions in the control register
`define CTL_LEAK_MON_BIT 0
`define CTL_MANUAL_BIT 1
// clear command fields: bit 4 suction cycles, bit 5 valve switchings, low nibble ejector
`define CLR_CYC_BIT 4
`define CLR_VLV_BIT 5
// values
`define LEAK_LIMIT_RESET 16'h00FA
`define LEAK_LIMIT_MAX 16'h03E7
`define CYC_PERM_MAX 32'h000F423F
`define CLR_CNT_MAX 32'h3B9AC9FF
`define SAVE_MASK 32'h000000FF
`define LEAK_TRIP_COUNT 2'h2
`endif

// ---- hw/ejector_bank_pkg.sv ----
`default_nettype none
package ejector_bank_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_read = 3'b010,
    st_done = 3'b100
  } bus_state_e;
  typedef logic [31:0] count_t;
  typedef logic [3:0] ejector_t;
endpackage : ejector_bank_pkg
`default_nettype wire

// ---- hw/ejector_channel.sv ----
`include "ejector_bank_defines.svh"
`default_nettype none
module ejector_channel (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic suction_rise,
  input wire logic valve_rise,
  input wire logic clear_cyc,
  input wire logic clear_vlv,
  input wire logic leak_valid,
  input wire logic [15:0] leak_rate,
  input wire logic [15:0] leak_limit,
  input wire logic leak_mon_en,
  output logic [31:0] cyc_perm,
  output logic [31:0] vlv_perm,
  output logic [31:0] cyc_clr,
  output logic [31:0] vlv_clr,
  output logic save_req,
  output logic force_continuous
);
  // ==========================================================
  // saturating increments
  wire logic [31:0] next_cyc_perm = (cyc_perm < `CYC_PERM_MAX) ? cyc_perm + 32'h1 : cyc_perm;
  wire logic [31:0] next_vlv_perm = (vlv_perm < `CYC_PERM_MAX) ? vlv_perm + 32'h1 : vlv_perm;
  wire logic [31:0] next_cyc_clr = (cyc_clr < `CLR_CNT_MAX) ? cyc_clr + 32'h1 : cyc_clr;
  wire logic [31:0] next_vlv_clr = (vlv_clr < `CLR_CNT_MAX) ? vlv_clr + 32'h1 : vlv_clr;
  // save on each 256th step of a permanent counter
  wire logic cyc_save = suction_rise && ((next_cyc_perm & `SAVE_MASK) == 32'h0)
    && (next_cyc_perm != cyc_perm);
  wire logic vlv_save = valve_rise && ((next_vlv_perm & `SAVE_MASK) == 32'h0)
    && (next_vlv_perm != vlv_perm);
  wire logic leak_over = leak_valid && (leak_rate > leak_limit);
  logic [1:0] over_run;

  // permanent counters, never cleared
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cyc_perm <= 32'h0;
      vlv_perm <= 32'h0;
    end else begin
      if (suction_rise) cyc_perm <= next_cyc_perm; // R4 R5 R9 R14
      if (valve_rise) vlv_perm <= next_vlv_perm; // R4 R6 R9 R14
    end
  end

  // clearable counters, an increment in the clear cycle counts as one
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cyc_clr <= 32'h0;
      vlv_clr <= 32'h0;
    end else begin
      if (clear_cyc) cyc_clr <= suction_rise ? 32'h1 : 32'h0; // R7
      else if (suction_rise) cyc_clr <= next_cyc_clr; // R10 R14
      if (clear_vlv) vlv_clr <= valve_rise ? 32'h1 : 32'h0; // R7
      else if (valve_rise) vlv_clr <= next_vlv_clr; // R10 R14
    end
  end

  // save strobe and leak trip
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      save_req <= 1'b0;
      over_run <= 2'h0;
      force_continuous <= 1'b0;
    end else begin
      save_req <= cyc_save || vlv_save; // R8
      if (!leak_mon_en) begin
        over_run <= 2'h0;
        force_continuous <= 1'b0;
      end else if (leak_valid) begin
        if (!leak_over) over_run <= 2'h0;
        else if (over_run == `LEAK_TRIP_COUNT) force_continuous <= 1'b1; // R13
        else over_run <= over_run + 2'h1;
      end
    end
  end

  a_perm_no_clear: assert property (@(posedge core_clk) disable iff (!rstn) // R7
    !suction_rise |=> cyc_perm == $past(cyc_perm)) else $error("perm count moved");
  a_clr_cap: assert property (@(posedge core_clk) disable iff (!rstn) // R14
    cyc_clr <= `CLR_CNT_MAX && vlv_clr <= `CLR_CNT_MAX) else $error("clr over max");
  a_perm_cap: assert property (@(posedge core_clk) disable iff (!rstn) // R9
    cyc_perm <= `CYC_PERM_MAX) else $error("perm over max");
  a_save_step: assert property (@(posedge core_clk) disable iff (!rstn) // R8
    save_req |-> (cyc_perm[7:0] == 8'h0 || vlv_perm[7:0] == 8'h0)) else $error("bad save");
  a_clear_zero: assert property (@(posedge core_clk) disable iff (!rstn) // R7
    clear_vlv && !valve_rise |=> vlv_clr == 32'h0) else $error("clear failed");
endmodule : ejector_channel
`default_nettype wire

// ---- verification/controller_model.sv ----
`default_nettype none
// ====
// controller side: suction command and valve switching
module controller_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [3:0] ej,
  output logic [15:0] suction_cmd,
  output logic [15:0] suction_valve
);
  timeunit 1ns;
  timeprecision 1ps;
  // one suction cycle and one valve switching per request, then idle low
  always_ff @(posedge core_clk) begin
    suction_cmd <= go ? 16'h0001 << ej : 16'h0000;
    suction_valve <= go ? 16'h0001 << ej : 16'h0000;
  end
endmodule : controller_model
`default_nettype wire

// ---- verification/testbench.sv ----
`include "ejector_bank_defines.svh"
`default_nettype none
// ====
// bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, rd_en = 1'b0, wr_en = 1'b0, go = 1'b0, btn = 1'b0;
  logic [13:0] addr = 14'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic wait_req, vp_en;
  logic [3:0] ej = 4'h0;
  logic [15:0] scmd, sval, s_out;
  logic [15:0] bcmd = 16'h0000, b_out;
  int fails = 0, tests_run = 0;
  controller_model u_ctl (.core_clk(core_clk), .go(go), .ej(ej), .suction_cmd(scmd),
    .suction_valve(sval));
  ejector_bank u_dut (.core_clk(core_clk), .rstn(rstn), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .suction_cmd(scmd),
    .blow_cmd(bcmd), .suction_valve(sval), .upper_vacuum_switch_point(16'h0000),
    .leak_valid(16'h0000), .leak_rate(256'h0), .panel_suction_btn(btn),
    .panel_blow_btn(1'b0), .suction_out(s_out), .blow_out(b_out), .valve_protect_en(vp_en),
    .force_continuous(), .save_req());
  // clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // one bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d,
      input logic [31:0] x);
    addr <= {i[9:0], ej};
    wdata <= d;
    rd_en <= !w;
    wr_en <= w;
    do @(posedge core_clk); while (wait_req !== 1'b0);
    if (!w) chk(rdata, x);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic summarize;
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #100000;
    fails++;
    summarize();
  end
  // tests
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(0, `IDX_LEAK_LIMIT, 0, 32'hFA);
    ej <= 4'hF;
    @(posedge core_clk);
    bus(0, `IDX_LEAK_LIMIT, 0, 32'hFA);
    bus(1, `IDX_LEAK_LIMIT, 32'h3E7, 0);
    bus(0, `IDX_LEAK_LIMIT, 0, 32'h3E7);
    bus(1, `IDX_LEAK_LIMIT, 32'h3E8, 0);
    bus(0, `IDX_LEAK_LIMIT, 0, 32'h3E7);
    ej <= 4'h2;
    repeat (3) begin
      go <= 1'b1;
      repeat (2) @(posedge core_clk);
      go <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    bus(0, `IDX_CYC_PERM, 0, 32'h3);
    bus(0, `IDX_CYC_CLR, 0, 32'h3);
    bus(0, `IDX_VLV_PERM, 0, 32'h3);
    bus(0, `IDX_VLV_CLR, 0, 32'h3);
    bus(1, `IDX_CYC_PERM, 32'h55, 0);
    bus(0, `IDX_CYC_PERM, 0, 32'h3);
    bus(1, `IDX_CLEAR_CMD, 32'h32, 0);
    repeat (2) @(posedge core_clk);
    bus(0, `IDX_CYC_CLR, 0, 32'h0);
    bus(0, `IDX_VLV_CLR, 0, 32'h0);
    bus(0, `IDX_VLV_PERM, 0, 32'h3);
    ej <= 4'h0;
    @(posedge core_clk);
    bus(0, `IDX_LEAK_LIMIT, 0, 32'hFA);
    bcmd <= 16'h0004;
    repeat (2) @(posedge core_clk);
    chk(b_out, 32'h4);
    chk(vp_en, 1);
    bus(1, `IDX_CONTROL, 32'h2, 0);
    btn <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(s_out[0], 1);
    chk(b_out, 0);
    chk(vp_en, 0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
